//--- mppio_pkg.sv
// Package of constants and types for the multi-port parallel I/O block
package mppio_pkg;
  // ==========================================================
  // Pad layout
  localparam int NPORT = 6;
  localparam int NPAD = 43;
  localparam int P1_LSB = 0;
  localparam int P2_LSB = 8;
  localparam int P3_LSB = 11;
  localparam int P4_LSB = 19;
  localparam int P5_LSB = 27;
  localparam int P6_LSB = 35;
  localparam int PORT_LSB [NPORT] = '{P1_LSB, P2_LSB, P3_LSB, P4_LSB, P5_LSB, P6_LSB};
  localparam int PORT_W [NPORT] = '{8, 3, 8, 8, 8, 8};
  localparam int P2_STOP_BIT = 0;
  localparam int P2_XIN_BIT = 1;
  localparam int P2_XOUT_BIT = 2;
  localparam int P4_IDX = 3;
  // ==========================================================
  // Register offsets
  localparam int AW = 12;
  localparam logic [AW-1:0] LAT_OFF [NPORT] =
    '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006};
  localparam logic [AW-1:0] DIR_OFF [NPORT] =
    '{12'h00a, 12'hfff, 12'h00c, 12'h00d, 12'h00e, 12'h02e};
  localparam logic [AW-1:0] OFF_P2_PIN = 12'h012;
  localparam logic [AW-1:0] OFF_P4_PIN = 12'h014;
  localparam logic [AW-1:0] OFF_P4_OD = 12'h02d;
  localparam logic [AW-1:0] OFF_ADC_CTRL = 12'h026;
  localparam logic [AW-1:0] OFF_P6_PU = 12'hfbc;
  // ==========================================================
  // Fields and reset values
  localparam int ADC_CH_LSB = 0;
  localparam int ADC_CH_W = 4;
  localparam int ADC_ANALOG_DISABLE_SELECT_BIT = 4;
  localparam logic [NPAD-1:0] LAT_RST = {8'h00, 8'h00, 8'hff, 8'hff, 3'h7, 8'h00};
  localparam logic [NPAD-1:0] DIR_RST = {NPAD{1'b0}};
  localparam logic [7:0] OD_RST = 8'h00;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic ANALOG_DISABLE_SELECT_RST = 1'b1;
  localparam logic [ADC_CH_W-1:0] CH_RST = 4'h0;
  // ==========================================================
  // Pad drive carrier
  typedef struct packed {
    logic [NPAD-1:0] out;
    logic [NPAD-1:0] oe;
  } mppio_pad_t;
endpackage

//--- mppio_top.sv
// Six-port parallel I/O with register access, pad sync and pad drive
// Behaviour
// - Port one: eight pins, direction and latch reset to zero.
// - Port two is three bits wide, latch resets to all ones.
// - Port two latch and pin levels read at separate addresses.
// - Port two read bits seven to three carry no value.
// - Stop mode forces port two pin zero to high impedance always.
// - Dual-clock mode gives port two pins one and two to oscillator.
// - Port three resets to input with latches all ones.
// - Port four resets to input with latches all ones.
// - Port four per-bit open-drain select, reset zero gives tri-state.
// - Port four latch and pin levels read at separate addresses.
// - Port four bit-op write keeps latch bits of input pins.
// - Port five: eight direction bits reset input, latches reset zero.
// - Port six resets cleared, analog disable set, inputs read zero.
// - Port six read returns zero on analog input bits.
// - Fixed-zero input pins always read zero regardless of pad or pull-up.
// - Port six pull-up enables reset zero, suppressed on output pins.
`timescale 1ns/1ps
module mppio_top
  import mppio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_bitop,
  output logic [7:0] reg_rdata,
  input wire logic [NPAD-1:0] pad_in,
  output mppio_pad_t pad,
  input wire logic [NPAD-1:0] alt_out,
  output logic [NPAD-1:0] pin_level,
  input wire logic stop_mode,
  input wire logic stop_output_hold_enable,
  input wire logic low_freq_osc_enable,
  output logic [7:0] analog_in_en,
  output logic [ADC_CH_W-1:0] conversion_channel_select,
  output logic [7:0] pullup_en
);
  // ==========================================================
  // State
  logic [NPAD-1:0] lat_ff;
  logic [NPAD-1:0] dir_ff;
  logic [7:0] od_ff;
  logic [7:0] pu_ff;
  logic analog_disable_select_ff;
  logic [ADC_CH_W-1:0] ch_ff;
  logic [NPAD-1:0] sync1_ff;
  logic [NPAD-1:0] sync2_ff;
  logic [NPAD-1:0] sync3_ff;
  logic [NPAD-1:0] pin_ff;
  logic [7:0] rdata_ff;
  logic [NPAD-1:0] nxt_lat;
  logic [NPAD-1:0] nxt_dir;
  logic [7:0] nxt_rdata;

  // ==========================================================
  // Register writes, one generate slice per port
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      localparam int L = PORT_LSB[gi];
      localparam int W = PORT_W[gi];
      wire lat_hit = reg_wr && (reg_addr == LAT_OFF[gi]);
      wire dir_hit = reg_wr && (reg_addr == DIR_OFF[gi]) && (gi != 1);
      wire [W-1:0] d_cur = dir_ff[L +: W];
      wire [W-1:0] l_cur = lat_ff[L +: W];
      wire [W-1:0] w_bits = reg_wdata[W-1:0];
      wire keep_in = reg_bitop && (gi == P4_IDX);
      // Port four bit-op write only lands on output pins
      wire [W-1:0] l_new = keep_in ? ((w_bits & d_cur) | (l_cur & ~d_cur)) : w_bits;
      assign nxt_lat[L +: W] = lat_hit ? l_new : l_cur;
      assign nxt_dir[L +: W] = dir_hit ? w_bits : d_cur;
    end
  endgenerate

  wire od_hit = reg_wr && (reg_addr == OFF_P4_OD);
  wire pu_hit = reg_wr && (reg_addr == OFF_P6_PU);
  wire adc_hit = reg_wr && (reg_addr == OFF_ADC_CTRL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_ff <= LAT_RST;
      dir_ff <= DIR_RST;
      od_ff <= OD_RST;
      pu_ff <= PU_RST;
      analog_disable_select_ff <= ANALOG_DISABLE_SELECT_RST;
      ch_ff <= CH_RST;
    end else begin
      lat_ff <= nxt_lat;
      dir_ff <= nxt_dir;
      if (od_hit) begin
        od_ff <= reg_wdata;
      end
      if (pu_hit) begin
        pu_ff <= reg_wdata;
      end
      if (adc_hit) begin
        analog_disable_select_ff <= reg_wdata[ADC_ANALOG_DISABLE_SELECT_BIT];
        ch_ff <= reg_wdata[ADC_CH_LSB +: ADC_CH_W];
      end
    end
  end

  // ==========================================================
  // Pad input synchroniser, level taken once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pin_ff <= '0;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_ff <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (pin_ff & (sync2_ff ^ sync3_ff));
    end
  end

  // ==========================================================
  // Port six mode decode
  wire [7:0] p6_dir = dir_ff[P6_LSB +: 8];
  wire [7:0] p6_lat = lat_ff[P6_LSB +: 8];
  wire [7:0] p6_zero_in = ~p6_dir & ~p6_lat;
  wire [7:0] p6_digital_in = ~p6_dir & p6_lat;
  wire [7:0] p6_read = (p6_dir & p6_lat) | (p6_digital_in & pin_ff[P6_LSB +: 8]);
  assign analog_in_en = p6_zero_in & {8{~analog_disable_select_ff}};
  assign pullup_en = pu_ff & ~p6_dir;
  assign conversion_channel_select = ch_ff;

  // ==========================================================
  // Port two oscillator hand-over
  wire [2:0] p2_osc_mask = low_freq_osc_enable ? 3'h6 : 3'h0;
  wire [2:0] p2_pin = pin_ff[P2_LSB +: 3] & ~p2_osc_mask;

  // ==========================================================
  // Read mux for single-address ports: output bits show latch
  wire [NPAD-1:0] mix_read = (dir_ff & lat_ff) | (~dir_ff & pin_ff);

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      LAT_OFF[0]: nxt_rdata = mix_read[P1_LSB +: 8];
      LAT_OFF[1]: nxt_rdata = {5'h00, lat_ff[P2_LSB +: 3]};
      OFF_P2_PIN: nxt_rdata = {5'h00, p2_pin};
      LAT_OFF[2]: nxt_rdata = mix_read[P3_LSB +: 8];
      LAT_OFF[3]: nxt_rdata = lat_ff[P4_LSB +: 8];
      OFF_P4_PIN: nxt_rdata = pin_ff[P4_LSB +: 8];
      LAT_OFF[4]: nxt_rdata = mix_read[P5_LSB +: 8];
      LAT_OFF[5]: nxt_rdata = p6_read;
      DIR_OFF[0]: nxt_rdata = dir_ff[P1_LSB +: 8];
      DIR_OFF[2]: nxt_rdata = dir_ff[P3_LSB +: 8];
      DIR_OFF[3]: nxt_rdata = dir_ff[P4_LSB +: 8];
      DIR_OFF[4]: nxt_rdata = dir_ff[P5_LSB +: 8];
      DIR_OFF[5]: nxt_rdata = p6_dir;
      OFF_P4_OD: nxt_rdata = od_ff;
      OFF_P6_PU: nxt_rdata = pu_ff;
      OFF_ADC_CTRL: nxt_rdata = {3'h0, analog_disable_select_ff, ch_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;
  assign pin_level = pin_ff;

  // ==========================================================
  // Pad drive
  wire [NPAD-1:0] drv_val = lat_ff & alt_out;
  wire [7:0] p4_oe = dir_ff[P4_LSB +: 8] & (~od_ff | ~drv_val[P4_LSB +: 8]);
  // Port two is sink-only: low latch pulls the pin down
  wire [2:0] p2_oe_raw = ~lat_ff[P2_LSB +: 3] & ~p2_osc_mask;
  wire [2:0] p2_stop_mask = stop_mode ? 3'h1 : 3'h0;
  wire [2:0] p2_oe = p2_oe_raw & ~p2_stop_mask;
  wire [NPAD-1:0] oe_run = {dir_ff[P6_LSB +: 8], dir_ff[P5_LSB +: 8], p4_oe,
                            dir_ff[P3_LSB +: 8], p2_oe, dir_ff[P1_LSB +: 8]};
  wire stop_float = stop_mode && !stop_output_hold_enable;

  assign pad.out = drv_val;
  assign pad.oe = stop_float ? '0 : oe_run;

  // ==========================================================
  // Checks
  p1_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    lat_ff[P1_LSB +: 8] == 8'h00 && dir_ff[P1_LSB +: 8] == 8'h00)
    else $error("port one reset state wrong");
  p2_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    lat_ff[P2_LSB +: 3] == 3'h7) else $error("port two latch not all ones");
  p2_pin_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_P2_PIN |=> reg_rdata == {5'h00, $past(p2_pin)})
    else $error("port two pin read wrong");
  p2_hi_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && (reg_addr == OFF_P2_PIN || reg_addr == LAT_OFF[1]) |=> reg_rdata[7:3] == 5'h00)
    else $error("port two upper bits set");
  p20_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_mode |-> !pad.oe[P2_LSB + P2_STOP_BIT]) else $error("stop release pin driven in stop");
  osc_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_freq_osc_enable |-> pad.oe[P2_LSB + P2_XOUT_BIT -: 2] == 2'b00)
    else $error("oscillator pins driven");
  p34_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    lat_ff[P3_LSB +: 16] == 16'hffff && dir_ff[P3_LSB +: 16] == 16'h0000)
    else $error("port three or four reset wrong");
  od_sink_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    od_ff[0] && drv_val[P4_LSB] |-> !pad.oe[P4_LSB]) else $error("open drain drives high");
  p4_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[3] |=> reg_rdata == $past(lat_ff[P4_LSB +: 8]))
    else $error("port four latch read wrong");
  bitop_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_bitop && reg_addr == LAT_OFF[3] |=>
    (lat_ff[P4_LSB +: 8] & ~$past(dir_ff[P4_LSB +: 8])) ==
    ($past(lat_ff[P4_LSB +: 8]) & ~$past(dir_ff[P4_LSB +: 8])))
    else $error("bit op hit input latch");
  p5_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    lat_ff[P5_LSB +: 8] == 8'h00 && dir_ff[P5_LSB +: 8] == 8'h00)
    else $error("port five reset wrong");
  p6_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    analog_disable_select_ff && analog_in_en == 8'h00 && p6_read == 8'h00) else $error("port six reset wrong");
  p6_zero_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[5] |=> (reg_rdata & $past(p6_zero_in)) == 8'h00)
    else $error("port six zero bit read high");
  analog_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    analog_in_en != 8'h00 |-> !analog_disable_select_ff && (analog_in_en & (p6_dir | p6_lat)) == 8'h00)
    else $error("analog mode decode wrong");
  pullup_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pullup_en & p6_dir) == 8'h00) else $error("pull-up on output pin");
  dir_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == DIR_OFF[4] |=> dir_ff[P5_LSB +: 8] == $past(reg_wdata))
    else $error("direction write lost");

  // ==========================================================
  // Drive and read-back checks
  p1_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !stop_float |-> pad.oe[P1_LSB +: 8] == dir_ff[P1_LSB +: 8])
    else $error("port one drive not from direction");
  p3_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !stop_float |-> pad.oe[P3_LSB +: 8] == dir_ff[P3_LSB +: 8])
    else $error("port three drive not from direction");
  p5_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !stop_float |-> pad.oe[P5_LSB +: 8] == dir_ff[P5_LSB +: 8])
    else $error("port five drive not from direction");
  p6_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !stop_float |-> pad.oe[P6_LSB +: 8] == p6_dir)
    else $error("port six drive not from direction");
  stop_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_mode && !stop_output_hold_enable |-> pad.oe == '0)
    else $error("pins driven in stop without hold");
  stop_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_mode && stop_output_hold_enable && !low_freq_osc_enable |->
    pad.oe[P2_LSB + 1 +: 2] == ~lat_ff[P2_LSB + 1 +: 2]) else $error("hold lost port two drive");
  osc_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_P2_PIN && low_freq_osc_enable |=> reg_rdata[2:1] == 2'b00)
    else $error("oscillator pins read high");
  p2_latch_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[1] |=> reg_rdata == {5'h00, $past(lat_ff[P2_LSB +: 3])})
    else $error("port two latch read wrong");
  p2_latch_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == LAT_OFF[1] |=> lat_ff[P2_LSB +: 3] == $past(reg_wdata[2:0]))
    else $error("port two latch write lost");
  p2_release_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    pad.oe[P2_LSB +: 3] == 3'h0) else $error("port two sinks after reset");
  p4_pin_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFF_P4_PIN |=> reg_rdata == $past(pin_ff[P4_LSB +: 8]))
    else $error("port four pin read wrong");
  p4_tristate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !stop_float |-> (dir_ff[P4_LSB +: 8] & ~od_ff & ~pad.oe[P4_LSB +: 8]) == 8'h00)
    else $error("tri-state output not driven");
  p4_input_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pad.oe[P4_LSB +: 8] & ~dir_ff[P4_LSB +: 8]) == 8'h00)
    else $error("port four input driven");
  style_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |->
    od_ff == 8'h00 && pu_ff == 8'h00) else $error("drive style or pull-up reset wrong");
  p6_out_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[5] |=>
    (reg_rdata & $past(p6_dir)) == ($past(p6_lat) & $past(p6_dir)))
    else $error("port six output bit read wrong");
  p6_in_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[5] |=>
    (reg_rdata & $past(p6_digital_in)) == ($past(pin_ff[P6_LSB +: 8]) & $past(p6_digital_in)))
    else $error("port six input bit read wrong");
  analog_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == LAT_OFF[5] |=> (reg_rdata & $past(analog_in_en)) == 8'h00)
    else $error("analog bit read high");
  pullup_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_P6_PU |=> pu_ff == $past(reg_wdata))
    else $error("pull-up write lost");
  p1_latch_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == LAT_OFF[0] |=> lat_ff[P1_LSB +: 8] == $past(reg_wdata))
    else $error("port one latch write lost");
  adc_disable_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFF_ADC_CTRL |=> analog_disable_select_ff == $past(reg_wdata[ADC_ANALOG_DISABLE_SELECT_BIT]))
    else $error("analog disable write lost");
  pin_agree_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sync2_ff == sync3_ff |=> pin_ff == $past(sync2_ff))
    else $error("pin level not taken on agreement");
endmodule

//--- mppio_board.sv
// Board-side model of the signals on the port pins
`timescale 1ns/1ps
module mppio_board
  import mppio_pkg::*;
(
  input mppio_pad_t pad,
  input wire logic [NPAD-1:0] ext_level,
  input wire logic [7:0] pullup_en,
  output logic [NPAD-1:0] pad_in
);
  logic [NPAD-1:0] pulled;
  // Pull-up only on port six, board level elsewhere when released
  assign pulled = {pullup_en, {P6_LSB{1'b0}}};
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & (ext_level | pulled));
endmodule

//--- multi_port_parallel_io_tb_top.sv
// Self-checking testbench for the multi-port parallel I/O block
`timescale 1ns/1ps
module multi_port_parallel_io_tb_top;
  import mppio_pkg::*;
  typedef struct packed {
    logic [11:0] wa;
    logic [7:0] wd;
    logic [11:0] ra;
    logic [7:0] ex;
  } mppio_tb_row_t;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_bitop = 0;
  logic stop_mode = 0, hold = 0, osc_en = 0;
  logic [NPAD-1:0] alt = {NPAD{1'b1}};
  logic [AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, analog_in_en, pullup_en;
  logic [ADC_CH_W-1:0] ch;
  logic [NPAD-1:0] pad_in, pin_level;
  logic [NPAD-1:0] ext = {8'hff, 8'h00, 8'hff, 8'h00, 3'h3, 8'h00};
  mppio_pad_t pad;
  int errors = 0, n_tests = 0;
  mppio_tb_row_t rows [13] = '{
    '{12'h000, 8'hff, 12'h002, 8'h07},
    '{12'h000, 8'hff, 12'h004, 8'hff},
    '{12'h000, 8'hff, 12'h006, 8'h00},
    '{12'h000, 8'hff, 12'h00d, 8'h00},
    '{12'h000, 8'hff, 12'h02d, 8'h00},
    '{12'h000, 8'hff, 12'hfbc, 8'h00},
    '{12'h000, 8'hff, 12'h026, 8'h10},
    '{12'h00a, 8'hff, 12'h001, 8'h00},
    '{12'h00e, 8'hff, 12'h005, 8'h00},
    '{12'h00c, 8'hff, 12'h003, 8'hff},
    '{12'h02e, 8'hff, 12'h006, 8'h00},
    '{12'h100, 8'ha5, 12'h100, 8'h00},
    '{12'h012, 8'hff, 12'h002, 8'h07}};
  always #5 sys_clk = ~sys_clk;
  mppio_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bitop(reg_bitop),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad(pad), .alt_out(alt),
    .pin_level(pin_level), .stop_mode(stop_mode), .stop_output_hold_enable(hold),
    .low_freq_osc_enable(osc_en), .analog_in_en(analog_in_en),
    .conversion_channel_select(ch), .pullup_en(pullup_en));
  mppio_board u_board (.pad(pad), .ext_level(ext), .pullup_en(pullup_en), .pad_in(pad_in));
  task automatic chk(input logic [NPAD-1:0] got, input logic [NPAD-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic b);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_bitop <= b;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_bitop <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic conclude();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    chk(pad.oe, '0);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, 1'b0);
      rd(rows[i].ra, rows[i].ex);
    end
    // Port two: bit0 sinks, bits 1 and 2 kept high as inputs
    wr(12'h002, 8'h06, 1'b0);
    repeat (6) @(posedge sys_clk);
    rd(12'h002, 8'h06);
    rd(12'h012, 8'h02);
    chk(pin_level[10:8], 3'h2);
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    hold <= 1'b1;
    #1 chk(pad.oe[P2_LSB], 1'b0);
    chk(pad.oe[7:0], 8'hff);
    // Stop without hold floats every pin
    @(posedge sys_clk);
    hold <= 1'b0;
    #1 chk(pad.oe, '0);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    hold <= 1'b1;
    #1 chk(pad.oe[P2_LSB], 1'b1);
    wr(12'h002, 8'h00, 1'b0);
    osc_en <= 1'b1;
    #1 chk(pad.oe[10:8], 3'h1);
    repeat (6) @(posedge sys_clk);
    rd(12'h012, 8'h00);
    @(posedge sys_clk);
    osc_en <= 1'b0;
    // Port four: mixed open-drain and directions, then a bit-op write
    wr(12'h02d, 8'h0f, 1'b0);
    wr(12'h00d, 8'h0f, 1'b0);
    wr(12'h004, 8'h05, 1'b0);
    #1 chk(pad.oe[26:19], 8'h0a);
    chk(pad.out[26:19], 8'h05);
    wr(12'h004, 8'hfa, 1'b1);
    rd(12'h004, 8'h0a);
    repeat (6) @(posedge sys_clk);
    rd(12'h014, 8'hfa);
    // Port one: inputs on 5:0, alternate outputs on 7:6 with latch high
    wr(12'h00a, 8'hc0, 1'b0);
    wr(12'h001, 8'hff, 1'b0);
    alt[7:0] <= 8'h7f;
    #1 chk(pad.oe[7:0], 8'hc0);
    chk(pad.out[7:6], 2'b01);
    rd(12'h001, 8'hc0);
    // Port three: serial outputs 7 and 5 and clock 3 out, the rest in
    wr(12'h00c, 8'ha8, 1'b0);
    #1 chk(pad.oe[18:11], 8'ha8);
    repeat (6) @(posedge sys_clk);
    rd(12'h003, 8'ha8);
    // Port six: outputs low nibble, digital inputs 5:4, zero-latch 7:6
    wr(12'h02e, 8'h0f, 1'b0);
    wr(12'h006, 8'h30, 1'b0);
    wr(12'hfbc, 8'hff, 1'b0);
    #1 chk(pullup_en, 8'hf0);
    chk(analog_in_en, 8'h00);
    repeat (6) @(posedge sys_clk);
    rd(12'h006, 8'h30);
    wr(12'h026, 8'h03, 1'b0);
    #1 chk(analog_in_en, 8'hc0);
    chk(ch, 4'h3);
    rd(12'h006, 8'h30);
    // Second reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(pad.oe, '0);
    chk(pin_level, '0);
    chk(analog_in_en, 8'h00);
    rst_n <= 1'b1;
    rd(12'h02e, 8'h00);
    rd(12'h026, 8'h10);
    rd(12'h004, 8'hff);
    conclude();
  end
endmodule
